// >>> rtl/cmc_defs.vh
// Constants for the core mode-control register bank
`ifndef CMC_DEFS_VH
`define CMC_DEFS_VH
// ==========================================
// Register select codes
`define CMC_SEL_MODE 1'b0
`define CMC_SEL_MASK 1'b1
// ==========================================
// Reset values
`define CMC_MODE_RST 32'h0000_0000
`define CMC_MASK_RST 32'h0020_0000
// ==========================================
// Writable bits of the mode word (reserved 9-8, 20-19, 31-25 and owner field excluded)
`define CMC_MODE_WMASK 32'h01e1_fcff
// Mask register follows the mode word bit for bit, reserved stay zero
`define CMC_MASK_WMASK 32'h01e7_fcff
// ==========================================
// Mode bit positions
`define CMC_B_BR8 0
`define CMC_B_BR0 1
`define CMC_B_ALT_RESULT_REGS_SEL 2
`define CMC_B_D1H 3
`define CMC_B_D1L 4
`define CMC_B_D2H 5
`define CMC_B_D2L 6
`define CMC_B_RFH 7
`define CMC_B_RFL 10
`define CMC_B_NEST 11
`define CMC_B_GIE 12
`define CMC_B_SAT 13
`define CMC_B_SSE 14
`define CMC_B_TRZ 15
`define CMC_B_R32 16
`define CMC_B_OWN_LO 17
`define CMC_B_OWN_HI 18
`define CMC_B_PE2 21
`define CMC_B_BC9 22
`define CMC_B_BC1 23
`define CMC_B_CBUF 24
// ==========================================
// Status stack depth
`define CMC_STK_DEPTH 3'h5
`define CMC_STK_AW 3
`endif

// >>> rtl/cmc_push_ctl.v
// Status push request combiner: instruction or qualifying interrupt entry
`timescale 1ns/1ps
module cmc_push_ctl (
	input wire push_instr_in,
	input wire [2:0] ext_irq_entry_in,
	input wire timer_irq_entry_in,
	output wire push_out
);
	// Any of the three external requests, timer expiry, or explicit push
	assign push_out = push_instr_in | (|ext_irq_entry_in) | timer_irq_entry_in; // RULE20
endmodule

// >>> rtl/cmc_stack.v
// Status stack holding saved mode words
`timescale 1ns/1ps
`include "cmc_defs.vh"
module cmc_stack (
	input wire mclk_in,
	input wire rst_b_in,
	input wire push_in,
	input wire pop_in,
	input wire [31:0] push_data_in,
	output wire [31:0] top_data_out,
	output wire empty_out,
	output wire full_out
);
	reg [31:0] mem [0:`CMC_STK_DEPTH-1];
	reg [`CMC_STK_AW-1:0] cnt_ff;
	wire [`CMC_STK_AW-1:0] top_idx;
	wire do_push;
	wire do_pop;
	// ==========================================
	// Pointer and flags; a push to a full stack is dropped
	assign empty_out = (cnt_ff == {`CMC_STK_AW{1'b0}});
	assign full_out = (cnt_ff == `CMC_STK_DEPTH);
	assign do_push = push_in & ~full_out;
	assign do_pop = pop_in & ~push_in & ~empty_out;
	assign top_idx = cnt_ff - 3'h1;
	assign top_data_out = empty_out ? `CMC_MODE_RST : mem[top_idx];
	// Occupancy count
	always @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cnt_ff <= 3'h0;
		end else if (do_push) begin
			cnt_ff <= cnt_ff + 3'h1;
		end else if (do_pop) begin
			cnt_ff <= cnt_ff - 3'h1;
		end
	end
	// Storage, no reset needed since reads are gated by the count
	always @(posedge mclk_in) begin
		if (do_push) begin
			mem[cnt_ff] <= push_data_in;
		end
	end
endmodule

// >>> rtl/cmc_regs.v
// Core mode-control register bank: mode word, clear mask and status push
`timescale 1ns/1ps
`include "cmc_defs.vh"
// Overview of operation
// (RULE1) Software writes zero to reserved bits
// (RULE2) Mode word resets to all zeros
// (RULE3) Bits 0,1 enable bit-reversed addressing
// (RULE4) Bit 2 selects secondary multiply results
// (RULE5) Bits 3-6 select secondary generator sets
// (RULE6) Bits 7,10 select secondary register-file halves
// (RULE7) Bit 11 permits nesting of higher priority
// (RULE8) Bit 12 gates all maskable interrupts
// (RULE9) Bit 13 saturates fixed-point overflow results
// (RULE10) Bit 14 sign-extends short words, else zero-fill
// (RULE11) Bit 15 rounds toward zero, else nearest
// (RULE12) Bit 16 rounds floats to 32 bits
// (RULE13) Bits 18-17 report bus ownership, 00 master
// (RULE14) Bit 21 enables second element, else sleeps
// (RULE15) Bit 22 broadcasts pm loads via idx9
// (RULE16) Bit 23 broadcasts dm loads via idx1
// (RULE17) Bit 24 enables circular buffer wrapping
// (RULE18) Mask resets to bit 21, maps bitwise
// (RULE19) Push clears mode bits set in mask
// (RULE20) Push on instruction, external or timer entry
// (RULE21) Unmodified mode word saved before clearing
module cmc_regs (
	input wire mclk_in,
	input wire rst_b_in,
	input wire wr_en_in,
	input wire wr_sel_in,
	input wire [31:0] wr_data_in,
	input wire rd_sel_in,
	output wire [31:0] rd_data_out,
	input wire push_instr_in,
	input wire pop_instr_in,
	input wire [2:0] ext_irq_entry_in,
	input wire timer_irq_entry_in,
	input wire [1:0] bus_owner_code_in,
	output wire stack_full_out,
	output wire stack_empty_out,
	output wire [31:0] core_mode_word_out,
	output wire bitrev_second_gen_idx8_out,
	output wire bitrev_first_gen_idx0_out,
	output wire alt_result_regs_sel_out,
	output wire alt_first_gen_upper_out,
	output wire alt_first_gen_lower_out,
	output wire alt_second_gen_upper_out,
	output wire alt_second_gen_lower_out,
	output wire alt_regfile_upper_out,
	output wire alt_regfile_lower_out,
	output wire irq_nesting_en_out,
	output wire global_irq_en_out,
	output wire fixed_saturate_sel_out,
	output wire short_word_sign_ext_out,
	output wire round_toward_zero_sel_out,
	output wire float_round_narrow_sel_out,
	output wire is_bus_master_out,
	output wire second_element_en_out,
	output wire second_element_sleep_out,
	output wire broadcast_pm_idx9_out,
	output wire broadcast_dm_idx1_out,
	output wire circular_addr_en_out
);
	// ==========================================
	// Reset release
	reg rst_s1_ff;
	reg rst_s2_ff;
	wire rst_b;
	always @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rst_s1_ff <= 1'b0;
			rst_s2_ff <= 1'b0;
		end else begin
			rst_s1_ff <= 1'b1;
			rst_s2_ff <= rst_s1_ff;
		end
	end
	assign rst_b = rst_s2_ff;

	// ==========================================
	// Bus owner code pin sync, three stages, accept when last two agree
	reg [1:0] own_s1_ff;
	reg [1:0] own_s2_ff;
	reg [1:0] own_s3_ff;
	reg [1:0] own_ff;
	always @(posedge mclk_in or negedge rst_b) begin
		if (!rst_b) begin
			own_s1_ff <= 2'h0;
			own_s2_ff <= 2'h0;
			own_s3_ff <= 2'h0;
			own_ff <= 2'h0;
		end else begin
			own_s1_ff <= bus_owner_code_in;
			own_s2_ff <= own_s1_ff;
			own_s3_ff <= own_s2_ff;
			if (own_s2_ff == own_s3_ff) begin
				own_ff <= own_s3_ff;
			end
		end
	end

	// ==========================================
	// Push request and status stack
	wire push;
	wire [31:0] stk_top;
	reg [31:0] mode_ff;
	reg [31:0] mask_ff;
	reg [31:0] nxt_mode;
	reg [31:0] nxt_mask;
	wire [31:0] mode_view;
	cmc_push_ctl u_push (
		.push_instr_in(push_instr_in),
		.ext_irq_entry_in(ext_irq_entry_in),
		.timer_irq_entry_in(timer_irq_entry_in),
		.push_out(push)
	);
	// Stack captures the word as seen before the mask clear
	cmc_stack u_stack (
		.mclk_in(mclk_in),
		.rst_b_in(rst_b),
		.push_in(push),
		.pop_in(pop_instr_in),
		.push_data_in(mode_view), // RULE21
		.top_data_out(stk_top),
		.empty_out(stack_empty_out),
		.full_out(stack_full_out)
	);

	// Owner field is read-only status, spliced into the visible word
	assign mode_view = {mode_ff[31:19], own_ff, mode_ff[16:0]}; // RULE13

	// ==========================================
	// Next-state of mode word: write, then push clear, or pop restore when there is no push
	// Reserved bits are forced to zero because software is expected to write zeros there
	always @* begin
		nxt_mode = mode_ff;
		if (wr_en_in && wr_sel_in == `CMC_SEL_MODE) begin
			nxt_mode = wr_data_in & `CMC_MODE_WMASK; // RULE1
		end
		if (push) begin
			nxt_mode = nxt_mode & ~mask_ff; // RULE19
		end else if (pop_instr_in && !stack_empty_out) begin
			nxt_mode = stk_top & `CMC_MODE_WMASK;
		end
	end

	// Next-state of clear mask
	always @* begin
		nxt_mask = mask_ff;
		if (wr_en_in && wr_sel_in == `CMC_SEL_MASK) begin
			nxt_mask = wr_data_in & `CMC_MASK_WMASK; // RULE18
		end
	end

	// Register update
	always @(posedge mclk_in or negedge rst_b) begin
		if (!rst_b) begin
			mode_ff <= `CMC_MODE_RST; // RULE2
			mask_ff <= `CMC_MASK_RST; // RULE18
		end else begin
			mode_ff <= nxt_mode;
			mask_ff <= nxt_mask;
		end
	end

	// ==========================================
	// Readback
	reg [31:0] rd_ff;
	always @(posedge mclk_in or negedge rst_b) begin
		if (!rst_b) begin
			rd_ff <= 32'h0000_0000;
		end else begin
			rd_ff <= (rd_sel_in == `CMC_SEL_MASK) ? mask_ff : mode_view;
		end
	end
	assign rd_data_out = rd_ff;
	assign core_mode_word_out = mode_view;

	// ==========================================
	// Mode decode to consumers
	assign bitrev_second_gen_idx8_out = mode_ff[`CMC_B_BR8]; // RULE3
	assign bitrev_first_gen_idx0_out = mode_ff[`CMC_B_BR0]; // RULE3
	assign alt_result_regs_sel_out = mode_ff[`CMC_B_ALT_RESULT_REGS_SEL]; // RULE4
	assign alt_first_gen_upper_out = mode_ff[`CMC_B_D1H]; // RULE5
	assign alt_first_gen_lower_out = mode_ff[`CMC_B_D1L]; // RULE5
	assign alt_second_gen_upper_out = mode_ff[`CMC_B_D2H]; // RULE5
	assign alt_second_gen_lower_out = mode_ff[`CMC_B_D2L]; // RULE5
	assign alt_regfile_upper_out = mode_ff[`CMC_B_RFH]; // RULE6
	assign alt_regfile_lower_out = mode_ff[`CMC_B_RFL]; // RULE6
	assign irq_nesting_en_out = mode_ff[`CMC_B_NEST]; // RULE7
	assign global_irq_en_out = mode_ff[`CMC_B_GIE]; // RULE8
	assign fixed_saturate_sel_out = mode_ff[`CMC_B_SAT]; // RULE9
	assign short_word_sign_ext_out = mode_ff[`CMC_B_SSE]; // RULE10
	assign round_toward_zero_sel_out = mode_ff[`CMC_B_TRZ]; // RULE11
	assign float_round_narrow_sel_out = mode_ff[`CMC_B_R32]; // RULE12
	assign is_bus_master_out = (own_ff == 2'h0); // RULE13
	assign second_element_en_out = mode_ff[`CMC_B_PE2]; // RULE14
	assign second_element_sleep_out = ~mode_ff[`CMC_B_PE2]; // RULE14
	assign broadcast_pm_idx9_out = mode_ff[`CMC_B_BC9]; // RULE15
	assign broadcast_dm_idx1_out = mode_ff[`CMC_B_BC1]; // RULE16
	assign circular_addr_en_out = mode_ff[`CMC_B_CBUF]; // RULE17
endmodule

// >>> sim/cmc_regs_sva.sv
// Concurrent checks on the ports of the core mode-control register bank
`timescale 1ns/1ps
`include "cmc_defs.vh"
module cmc_regs_sva (
	input wire mclk_in,
	input wire rst_b_in,
	input wire wr_en_in,
	input wire wr_sel_in,
	input wire [31:0] wr_data_in,
	input wire push_instr_in,
	input wire pop_instr_in,
	input wire [2:0] ext_irq_entry_in,
	input wire timer_irq_entry_in,
	input wire stack_full_out,
	input wire [31:0] core_mode_word_out,
	input wire global_irq_en_out,
	input wire is_bus_master_out,
	input wire second_element_en_out,
	input wire second_element_sleep_out
);
// ==========================================
// Helper logic
wire push_any = push_instr_in | (|ext_irq_entry_in) | timer_irq_entry_in;
// Owner field comes from a pin, so it is left out of stored-bit checks
wire [31:0] mode_w = core_mode_word_out & `CMC_MODE_WMASK;
reg [31:0] mask_ff;
// Shadow of the clear mask, which is not visible at the ports
always @(posedge mclk_in or negedge rst_b_in) begin
	if (!rst_b_in)
		mask_ff <= `CMC_MASK_RST;
	else if (wr_en_in && wr_sel_in)
		mask_ff <= wr_data_in & `CMC_MASK_WMASK;
end
// ==========================================
// Properties
default clocking @(posedge mclk_in); endclocking
default disable iff (!rst_b_in);
sequence s_push; push_any && !wr_en_in && !stack_full_out; endsequence
sequence s_idle; !wr_en_in && !push_any && !pop_instr_in; endsequence
sequence s_pop; pop_instr_in && !push_any && !wr_en_in; endsequence
property p_rst_zero; $rose(rst_b_in) |-> mode_w == 32'h0; endproperty
a_rst_zero: assert property (p_rst_zero) else $error("mode not zero after reset");
property p_wr; wr_en_in && !wr_sel_in && !push_any && !pop_instr_in
	|=> mode_w == ($past(wr_data_in) & `CMC_MODE_WMASK); endproperty
a_wr: assert property (p_wr) else $error("mode write lost");
property p_resv; (core_mode_word_out & ~(`CMC_MODE_WMASK | 32'h0006_0000)) == 32'h0; endproperty
a_resv: assert property (p_resv) else $error("reserved mode bit set");
property p_clr; s_push |=> mode_w == ($past(mode_w) & ~$past(mask_ff)); endproperty
a_clr: assert property (p_clr) else $error("push clear wrong");
property p_src; (ext_irq_entry_in != 3'h0 || timer_irq_entry_in) && !wr_en_in
	|=> (mode_w & $past(mask_ff)) == 32'h0; endproperty
a_src: assert property (p_src) else $error("irq entry did not clear");
property p_restore; s_push ##1 s_idle ##1 s_pop |=> mode_w == $past(mode_w, 3); endproperty
a_restore: assert property (p_restore) else $error("pop did not restore");
property p_hold; s_idle |=> $stable(mode_w); endproperty
a_hold: assert property (p_hold) else $error("mode changed while idle");
property p_gie; global_irq_en_out == core_mode_word_out[12]; endproperty
a_gie: assert property (p_gie) else $error("irq gate mismatch");
property p_pe2; second_element_en_out == core_mode_word_out[21]
	&& second_element_sleep_out != core_mode_word_out[21]; endproperty
a_pe2: assert property (p_pe2) else $error("element enable mismatch");
property p_own; is_bus_master_out == (core_mode_word_out[18:17] == 2'b00); endproperty
a_own: assert property (p_own) else $error("bus master flag mismatch");
endmodule
bind cmc_regs cmc_regs_sva u_sva (.*);

// >>> sim/testbench.sv
// Self-checking testbench for the core mode-control register bank
`timescale 1ns/1ps
module testbench;
reg mclk_in = 1'b0, rst_b_in = 1'b0, wr_en_in = 1'b0, wr_sel_in = 1'b0, rd_sel_in = 1'b0;
reg push_instr_in = 1'b0, pop_instr_in = 1'b0, timer_irq_entry_in = 1'b0;
reg [2:0] ext_irq_entry_in = 3'h0;
reg [1:0] bus_owner_code_in = 2'h0;
reg [31:0] wr_data_in = 32'h0;
wire [31:0] rd_data_out, core_mode_word_out;
wire [18:0] bo;
wire stack_full_out, stack_empty_out, is_bus_master_out, second_element_sleep_out;
integer n_mismatch = 0, check_count = 0, i;
// Legal patterns that set and clear every writable mode bit
localparam [127:0] PATS = 128'h01e1fcff_0141a8aa_00a05455_00000000;
cmc_regs dut (.*, .bitrev_second_gen_idx8_out(bo[0]), .bitrev_first_gen_idx0_out(bo[1]),
	.alt_result_regs_sel_out(bo[2]), .alt_first_gen_upper_out(bo[3]),
	.alt_first_gen_lower_out(bo[4]), .alt_second_gen_upper_out(bo[5]),
	.alt_second_gen_lower_out(bo[6]), .alt_regfile_upper_out(bo[7]),
	.alt_regfile_lower_out(bo[8]), .irq_nesting_en_out(bo[9]), .global_irq_en_out(bo[10]),
	.fixed_saturate_sel_out(bo[11]), .short_word_sign_ext_out(bo[12]),
	.round_toward_zero_sel_out(bo[13]), .float_round_narrow_sel_out(bo[14]),
	.second_element_en_out(bo[15]), .broadcast_pm_idx9_out(bo[16]),
	.broadcast_dm_idx1_out(bo[17]), .circular_addr_en_out(bo[18]));
// 200 MHz core clock
always #2.5 mclk_in = ~mclk_in;
// ==========================================
// Access tasks
task chk(input [31:0] g, input [31:0] e);
	begin
		check_count = check_count + 1;
		if (g !== e) begin
			$display("[ERR] %0t got=%h exp=%h", $time, g, e);
			n_mismatch = n_mismatch + 1;
		end
	end
endtask
task wr(input s, input [31:0] d);
	begin
		@(posedge mclk_in);
		wr_en_in <= 1'b1;
		wr_sel_in <= s;
		wr_data_in <= d;
		@(posedge mclk_in);
		wr_en_in <= 1'b0;
		#1;
	end
endtask
// Readback is registered, so it is looked at one edge after the select
task rd(input s, input [31:0] e);
	begin
		@(posedge mclk_in);
		rd_sel_in <= s;
		@(posedge mclk_in);
		#1;
		chk(rd_data_out, e);
	end
endtask
// Pulse of {pop, timer, ext[2:0], push} for one cycle
task ev(input [5:0] v);
	begin
		@(posedge mclk_in);
		{pop_instr_in, timer_irq_entry_in, ext_irq_entry_in, push_instr_in} <= v;
		@(posedge mclk_in);
		{pop_instr_in, timer_irq_entry_in, ext_irq_entry_in, push_instr_in} <= 6'h0;
		#1;
	end
endtask
task stop_test;
	begin
		$display("checks=%0d mismatches=%0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
endtask
// ==========================================
// Tests
initial begin
	repeat (16) @(posedge mclk_in);
	rst_b_in <= 1'b1;
	repeat (3) @(posedge mclk_in);
	rd(1'b0, 32'h0);
	rd(1'b1, 32'h0020_0000);
	for (i = 0; i < 4; i = i + 1) begin
		wr(1'b0, PATS[32*i +: 32]);
		chk(32'(bo[7:0]), 32'(PATS[32*i +: 8]));
		chk(32'(bo[10:8]), 32'(PATS[32*i+10 +: 3]));
		chk(32'(bo[14:11]), 32'(PATS[32*i+13 +: 4]));
		chk(32'(bo[18:15]), 32'(PATS[32*i+21 +: 4]));
		chk(32'(second_element_sleep_out), 32'(!PATS[32*i+21]));
		rd(1'b0, PATS[32*i +: 32]);
	end
	// Owner code crosses a synchroniser, so allow it a few cycles
	for (i = 0; i < 4; i = i + 1) begin
		@(posedge mclk_in);
		bus_owner_code_in <= i[1:0];
		repeat (6) @(posedge mclk_in);
		#1;
		chk(32'(core_mode_word_out[18:17]), i);
		chk(32'(is_bus_master_out), 32'(i == 0));
	end
	@(posedge mclk_in);
	bus_owner_code_in <= 2'h0;
	repeat (6) @(posedge mclk_in);
	wr(1'b1, 32'h0020_2001);
	rd(1'b1, 32'h0020_2001);
	// Every push source in turn, each followed by a restoring pop
	for (i = 0; i < 5; i = i + 1) begin
		wr(1'b0, 32'h0120_2811);
		ev(6'h1 << i);
		chk(core_mode_word_out, 32'h0100_0810);
		chk(32'(stack_empty_out), 32'h0);
		ev(6'h20);
		chk(core_mode_word_out, 32'h0120_2811);
	end
	// Fill the stack; the sixth push is dropped but still clears
	for (i = 0; i < 6; i = i + 1) begin
		wr(1'b0, (32'h1 << i) | 32'h0000_2000);
		ev(6'h1);
	end
	chk(32'(stack_full_out), 32'h1);
	chk(core_mode_word_out, 32'h0000_0020);
	// Unwind newest first, then a pop on the empty stack changes nothing
	for (i = 4; i >= 0; i = i - 1) begin
		ev(6'h20);
		chk(core_mode_word_out, (32'h1 << i) | 32'h0000_2000);
	end
	chk(32'(stack_empty_out), 32'h1);
	ev(6'h20);
	chk(core_mode_word_out, 32'h0000_2001);
	// Push and pop together: the push wins
	ev(6'h21);
	chk(core_mode_word_out, 32'h0000_0000);
	ev(6'h20);
	chk(core_mode_word_out, 32'h0000_2001);
	// Reset in mid-run with a word on the stack
	ev(6'h1);
	@(posedge mclk_in);
	rst_b_in <= 1'b0;
	repeat (4) @(posedge mclk_in);
	rst_b_in <= 1'b1;
	repeat (3) @(posedge mclk_in);
	rd(1'b0, 32'h0);
	rd(1'b1, 32'h0020_0000);
	chk(32'(stack_empty_out), 32'h1);
	stop_test;
end
// Watchdog well beyond the roughly 160 cycles the tests need
initial begin
	repeat (3000) @(posedge mclk_in);
	n_mismatch = n_mismatch + 1;
	stop_test;
end
endmodule
